/* File: core/dcfsf_pkg.sv */
package dcfsf_pkg;
  // ---------------------------------------------------------------
  // array geometry
  // ---------------------------------------------------------------
  localparam int DCFSF_DATA_W = 9;
  localparam int DCFSF_MAX_DEPTH = 4096;
  localparam int DCFSF_ADDR_W = 12;
  localparam int DCFSF_PTR_W = 13;
  localparam logic [2:0] DCFSF_DEPTH_CODE_MAX = 3'h4;
  localparam logic [2:0] DCFSF_DEPTH_CODE_RST = 3'h4;
  localparam logic [12:0] DCFSF_DEPTH_BASE = 13'h0100;
  // ---------------------------------------------------------------
  // offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] DCFSF_OFFSET_DEFAULT = 12'h007;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int DCFSF_PADDR_W = 12;
  localparam logic [11:0] DCFSF_REG_DEPTH = 12'h000;
  localparam logic [11:0] DCFSF_REG_EMPTY_OFF = 12'h004;
  localparam logic [11:0] DCFSF_REG_FULL_OFF = 12'h008;
  localparam logic [11:0] DCFSF_REG_STATUS = 12'h00c;
  // status field positions
  localparam int DCFSF_ST_FULL = 0;
  localparam int DCFSF_ST_AFULL = 1;
  localparam int DCFSF_ST_AEMPTY = 2;
  localparam int DCFSF_ST_EMPTY = 3;
  localparam int DCFSF_ST_MODE = 4;
  localparam int DCFSF_ST_COUNT_LSB = 8;
  // ---------------------------------------------------------------
  // configuration mode caught during fifo reset
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    DCFSF_MODE_LOAD = 1'b0,
    DCFSF_MODE_SECOND_WE = 1'b1
  } dcfsf_mode_type;
endpackage : dcfsf_pkg

/* File: core/dcfsf_apb_regs.sv */
`timescale 1ns/1ps
module dcfsf_apb_regs
  import dcfsf_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fifo_reset_n,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration out
  output logic [2:0] depth_code,
  output logic [11:0] empty_offset,
  output logic [11:0] full_offset,
  // status in
  input wire logic [31:0] status_word
);
  logic access;
  logic hit;
  logic [31:0] rd_mux;

  // one wait state: pready rises in the second access cycle
  assign access = psel & penable & ~pready;

  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      DCFSF_REG_DEPTH: rd_mux = {29'h0, depth_code};
      DCFSF_REG_EMPTY_OFF: rd_mux = {20'h0_0000, empty_offset};
      DCFSF_REG_FULL_OFF: rd_mux = {20'h0_0000, full_offset};
      DCFSF_REG_STATUS: rd_mux = status_word;
      default: hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // bus answer
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access;
      pslverr <= access & ~hit;
      prdata <= (access & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // writable fields
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      depth_code <= DCFSF_DEPTH_CODE_RST;
    end else if (psel && penable && pready && pwrite && paddr == DCFSF_REG_DEPTH) begin
      depth_code <= (pwdata[2:0] > DCFSF_DEPTH_CODE_MAX) ? DCFSF_DEPTH_CODE_MAX : pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      empty_offset <= DCFSF_OFFSET_DEFAULT;
      full_offset <= DCFSF_OFFSET_DEFAULT;
    end else if (!fifo_reset_n) begin
      empty_offset <= DCFSF_OFFSET_DEFAULT;
      full_offset <= DCFSF_OFFSET_DEFAULT;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == DCFSF_REG_EMPTY_OFF) begin
        empty_offset <= pwdata[11:0];
      end
      if (paddr == DCFSF_REG_FULL_OFF) begin
        full_offset <= pwdata[11:0];
      end
    end
  end
endmodule : dcfsf_apb_regs

/* File: core/dcfsf_fifo.sv */
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module dcfsf_fifo
  import dcfsf_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fifo control pins
  input wire logic fifo_reset_n,
  input wire logic write_clock,
  input wire logic read_clock,
  input wire logic write_enable_primary_n,
  input wire logic write_enable_second_or_load,
  input wire logic read_enable_primary_n,
  input wire logic read_enable_second_n,
  input wire logic output_enable_n,
  // data
  input wire logic [8:0] data_in,
  output logic [8:0] data_out,
  output logic data_out_oe_n,
  // flags
  output logic full_flag_n,
  output logic almost_full_flag_n,
  output logic almost_empty_flag_n,
  output logic empty_flag_n
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [12:0] depth_of(input logic [2:0] code);
    depth_of = DCFSF_DEPTH_BASE << code;
  endfunction : depth_of

  // pointers carry one extra lap bit so full and empty differ;
  // at the largest depth the shift wraps to zero and the mask becomes all ones
  function automatic logic [12:0] lap_mask(input logic [12:0] d);
    lap_mask = (d << 1) - 13'h0001;
  endfunction : lap_mask

  function automatic logic [12:0] count_of(input logic [12:0] w, input logic [12:0] r,
                                            input logic [12:0] d);
    count_of = (w - r) & lap_mask(d);
  endfunction : count_of

  function automatic logic [12:0] ptr_inc(input logic [12:0] p, input logic [12:0] d);
    ptr_inc = (p + 13'h0001) & lap_mask(d);
  endfunction : ptr_inc

  // array slot of a pointer: the lap bit is dropped
  function automatic logic [11:0] slot_of(input logic [12:0] p, input logic [12:0] d);
    slot_of = p[11:0] & (d[11:0] - 12'h001);
  endfunction : slot_of

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [8:0] mem [0:DCFSF_MAX_DEPTH-1];
  logic [12:0] wptr_r;
  logic [12:0] wptr_nxt;
  logic [12:0] rptr_r;
  logic [12:0] rptr_nxt;
  logic wclk_d_r;
  logic rclk_d_r;
  logic wr_edge;
  logic rd_edge;
  logic do_write;
  logic do_read;
  logic [2:0] depth_code;
  logic [12:0] depth;
  logic [11:0] empty_offset_reg;
  logic [11:0] full_offset_reg;
  logic [12:0] m_eff;
  logic [12:0] n_eff;
  logic [12:0] cnt_w;
  logic [12:0] cnt_r;
  logic [12:0] cnt_now;
  dcfsf_mode_type mode_r;
  logic [8:0] out_reg_r;
  logic [31:0] status_word;
  logic [11:0] waddr;
  logic [11:0] raddr;
  logic full_nxt;
  logic afull_nxt;
  logic empty_nxt;
  logic aempty_nxt;

  // ---------------------------------------------------------------
  // clock pins sampled as ordinary inputs; rising edges become enables
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wclk_d_r <= 1'b0;
      rclk_d_r <= 1'b0;
    end else begin
      wclk_d_r <= write_clock;
      rclk_d_r <= read_clock;
    end
  end

  assign wr_edge = write_clock & ~wclk_d_r;
  assign rd_edge = read_clock & ~rclk_d_r;
  assign depth = depth_of(depth_code);

  // ---------------------------------------------------------------
  // mode strap
  // ---------------------------------------------------------------
  // strap caught during reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= DCFSF_MODE_LOAD;
    end else if (!fifo_reset_n) begin
      mode_r <= write_enable_second_or_load ? DCFSF_MODE_SECOND_WE : DCFSF_MODE_LOAD;
    end
  end

  assign m_eff = {1'b0,
                  (mode_r == DCFSF_MODE_SECOND_WE) ? DCFSF_OFFSET_DEFAULT : full_offset_reg};
  assign n_eff = {1'b0,
                  (mode_r == DCFSF_MODE_SECOND_WE) ? DCFSF_OFFSET_DEFAULT : empty_offset_reg};

  // ---------------------------------------------------------------
  // write and read qualification
  // ---------------------------------------------------------------
  // write gated by enables and full; the pin must be high in either mode
  // since in load mode a low pin writes nothing; offsets come over APB
  assign do_write = wr_edge & fifo_reset_n & ~write_enable_primary_n
                    & write_enable_second_or_load & full_flag_n;
  // read needs both enables, not empty
  assign do_read = rd_edge & fifo_reset_n & ~read_enable_primary_n
                   & ~read_enable_second_n & empty_flag_n;

  assign wptr_nxt = do_write ? ptr_inc(wptr_r, depth) : wptr_r;
  assign rptr_nxt = do_read ? ptr_inc(rptr_r, depth) : rptr_r;
  assign waddr = slot_of(wptr_r, depth);
  assign raddr = slot_of(rptr_r, depth);

  assign cnt_w = count_of(wptr_nxt, rptr_r, depth);
  assign cnt_r = count_of(wptr_r, rptr_nxt, depth);
  assign cnt_now = count_of(wptr_r, rptr_r, depth);

  // flag levels as the next write or read edge will see them; a full offset
  // at or above the depth wraps the threshold, so software keeps m below it
  assign full_nxt = ~(cnt_w == depth);
  assign afull_nxt = ~(cnt_w >= depth - m_eff);
  assign empty_nxt = ~(cnt_r == 13'h0000);
  assign aempty_nxt = ~(cnt_r <= n_eff);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (do_write) begin
      mem[waddr] <= data_in;
    end
  end

  // ---------------------------------------------------------------
  // pointers
  // ---------------------------------------------------------------
  // reset clears pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_r <= 13'h0000;
      rptr_r <= 13'h0000;
    end else if (!fifo_reset_n) begin
      wptr_r <= 13'h0000;
      rptr_r <= 13'h0000;
    end else begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
    end
  end

  // ---------------------------------------------------------------
  // write-side flags
  // ---------------------------------------------------------------
  // the read pointer is seen as it stands this cycle, so a read in the
  // same cycle as a write edge shows up one write edge later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_flag_n <= 1'b1;
      almost_full_flag_n <= 1'b1;
    end else if (!fifo_reset_n) begin
      full_flag_n <= 1'b1;
      almost_full_flag_n <= 1'b1;
    end else if (wr_edge) begin
      full_flag_n <= full_nxt;
      almost_full_flag_n <= afull_nxt;
    end
  end

  // ---------------------------------------------------------------
  // read-side flags
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      empty_flag_n <= 1'b0;
      almost_empty_flag_n <= 1'b0;
    end else if (!fifo_reset_n) begin
      empty_flag_n <= 1'b0;
      almost_empty_flag_n <= 1'b0;
    end else if (rd_edge) begin
      empty_flag_n <= empty_nxt;
      almost_empty_flag_n <= aempty_nxt;
    end
  end

  // ---------------------------------------------------------------
  // output register and pins
  // ---------------------------------------------------------------
  // output holds unless read; fifo reset clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg_r <= 9'h000;
    end else if (!fifo_reset_n) begin
      out_reg_r <= 9'h000;
    end else if (do_read) begin
      out_reg_r <= mem[raddr];
    end
  end

  // pins lag the output register by one pclk so they come from flops
  // output low when enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_out <= 9'h000;
      data_out_oe_n <= 1'b1;
    end else begin
      data_out <= out_reg_r;
      data_out_oe_n <= output_enable_n;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  assign status_word = {11'h000, cnt_now, 3'h0, mode_r, empty_flag_n,
                        almost_empty_flag_n, almost_full_flag_n, full_flag_n};

  dcfsf_apb_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .fifo_reset_n(fifo_reset_n),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .depth_code(depth_code),
    .empty_offset(empty_offset_reg),
    .full_offset(full_offset_reg),
    .status_word(status_word)
  );
endmodule : dcfsf_fifo

/* File: verification/dcfsf_monitor.sv */
`timescale 1ns/1ps
module dcfsf_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fifo_reset_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // fifo pins
  input wire logic write_clock,
  input wire logic read_clock,
  input wire logic read_enable_primary_n,
  input wire logic read_enable_second_n,
  input wire logic [8:0] data_out,
  // flags
  input wire logic full_flag_n,
  input wire logic almost_full_flag_n,
  input wire logic almost_empty_flag_n,
  input wire logic empty_flag_n
);
  logic wc_q;
  logic rc_q;
  logic wr_e;
  logic rd_e;
  logic rd_ok;
  // one pclk of history turns sampled clock levels into edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wc_q <= 1'b0;
      rc_q <= 1'b0;
    end else begin
      wc_q <= write_clock;
      rc_q <= read_clock;
    end
  end
  assign wr_e = write_clock & ~wc_q;
  assign rd_e = read_clock & ~rc_q;
  assign rd_ok = rd_e & ~read_enable_primary_n & ~read_enable_second_n & empty_flag_n;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !fifo_reset_n);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_rst2;
    !fifo_reset_n ##1 !fifo_reset_n;
  endsequence
  property p_full_hold;
    !wr_e |=> $stable(full_flag_n);
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("full flag moved off a write edge");
  property p_afull_hold;
    !wr_e |=> $stable(almost_full_flag_n);
  endproperty
  a_afull_hold: assert property (p_afull_hold) else $error("almost full off write edge");
  property p_aempty_hold;
    !rd_e |=> $stable(almost_empty_flag_n);
  endproperty
  a_aempty_hold: assert property (p_aempty_hold) else $error("almost empty off read edge");
  property p_empty_hold;
    !rd_e |=> $stable(empty_flag_n);
  endproperty
  a_empty_hold: assert property (p_empty_hold) else $error("empty flag off read edge");
  property p_full_afull;
    !full_flag_n |-> !almost_full_flag_n;
  endproperty
  a_full_afull: assert property (p_full_afull) else $error("full without almost full");
  property p_empty_aempty;
    !empty_flag_n |-> !almost_empty_flag_n;
  endproperty
  a_empty_aempty: assert property (p_empty_aempty) else $error("empty without almost empty");
  property p_out_hold;
    !rd_ok |-> ##2 $stable(data_out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output changed without a read");
  property p_rst_flags;
    disable iff (!presetn) !fifo_reset_n |=> full_flag_n && almost_full_flag_n
      && !almost_empty_flag_n && !empty_flag_n;
  endproperty
  a_rst_flags: assert property (p_rst_flags) else $error("flags wrong in fifo reset");
  property p_rst_data;
    disable iff (!presetn) s_rst2 |=> data_out == 9'h000;
  endproperty
  a_rst_data: assert property (p_rst_data) else $error("output not cleared by reset");
  property p_apb_wait;
    disable iff (!presetn) s_access |=> pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb answer not after one wait");
endmodule : dcfsf_monitor

/* File: verification/dcfsf_far_side.sv */
`timescale 1ns/1ps
module dcfsf_far_side (
  // clock
  input wire logic pclk,
  // requests
  input wire logic wr_go,
  input wire logic rd_go,
  // clocks to the fifo
  output logic write_clock,
  output logic read_clock
);
  // both clocks start low so the toggling below never sticks at unknown
  initial begin
    write_clock = 1'b0;
    read_clock = 1'b0;
  end

  // clocks may run in reset
  // each level lasts one pclk so the sampler never misses an edge
  always @(posedge pclk) begin
    write_clock <= wr_go & ~write_clock;
    read_clock <= rd_go & ~read_clock;
  end
endmodule : dcfsf_far_side

/* File: verification/dual_clock_fifo_status_flags_tb_top.sv */
`timescale 1ns/1ps
module dual_clock_fifo_status_flags_tb_top import dcfsf_pkg::*; ;
  typedef struct packed {
    logic [11:0] a;
    logic w;
    logic [31:0] d;
    logic [31:0] e;
    logic r;
  } dcfsf_row_type;
  logic pclk = 1'b0;
  logic presetn, fifo_reset_n, psel, penable, pwrite, pready, pslverr, wr_go, rd_go, er;
  logic write_clock, read_clock, write_enable_primary_n, write_enable_second_or_load;
  logic read_enable_primary_n, read_enable_second_n, output_enable_n, data_out_oe_n;
  logic full_flag_n, almost_full_flag_n, almost_empty_flag_n, empty_flag_n, ff, af, ef, ae;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0] data_in, data_out, dout;
  logic [8:0] q [$];
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  int cnt, dep, n, m;
  dcfsf_row_type rows [14] = '{
    '{DCFSF_REG_DEPTH, 1'b0, 32'h0, 32'h4, 1'b0}, '{DCFSF_REG_EMPTY_OFF, 1'b0, 32'h0, 32'h7, 1'b0},
    '{DCFSF_REG_FULL_OFF, 1'b0, 32'h0, 32'h7, 1'b0}, '{DCFSF_REG_DEPTH, 1'b1, 32'h7, 32'h0, 1'b0},
    '{DCFSF_REG_DEPTH, 1'b0, 32'h0, 32'h4, 1'b0}, '{DCFSF_REG_DEPTH, 1'b1, 32'h0, 32'h0, 1'b0},
    '{DCFSF_REG_DEPTH, 1'b0, 32'h0, 32'h0, 1'b0}, '{12'h010, 1'b0, 32'h0, 32'h0, 1'b1},
    '{DCFSF_REG_STATUS, 1'b0, 32'h0, 32'h3, 1'b0}, '{DCFSF_REG_EMPTY_OFF, 1'b1, 32'h3, 32'h0, 1'b0},
    '{DCFSF_REG_EMPTY_OFF, 1'b0, 32'h0, 32'h3, 1'b0}, '{DCFSF_REG_FULL_OFF, 1'b1, 32'h5, 32'h0, 1'b0},
    '{DCFSF_REG_FULL_OFF, 1'b0, 32'h0, 32'h5, 1'b0}, '{12'h010, 1'b1, 32'h9, 32'h0, 1'b1}};
  dcfsf_fifo uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .fifo_reset_n, .write_clock, .read_clock, .write_enable_primary_n,
    .write_enable_second_or_load, .read_enable_primary_n, .read_enable_second_n,
    .output_enable_n, .data_in, .data_out, .data_out_oe_n, .full_flag_n, .almost_full_flag_n,
    .almost_empty_flag_n, .empty_flag_n);
  dcfsf_far_side u_far (.pclk, .wr_go, .rd_go, .write_clock, .read_clock);
  always #12.5 pclk = ~pclk;
  // a hang is cut short well past the expected run of about 3200 cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 12000) begin
      failures++;
      results();
    end
  end
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // en is write primary, second or load, read primary, read second
  task automatic op(input logic w, input logic [3:0] en, input logic [8:0] d);
    @(posedge pclk);
    wr_go <= w;
    rd_go <= ~w;
    {write_enable_primary_n, write_enable_second_or_load} <= en[3:2];
    {read_enable_primary_n, read_enable_second_n} <= en[1:0];
    data_in <= d;
    @(posedge pclk);
    wr_go <= 1'b0;
    rd_go <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    if (w && ff && en[3:2] == 2'b01) q.push_back(d);
    if (!w && ef && en[1:0] == 2'b00) dout = q.pop_front();
    cnt = q.size();
    ff = w ? (cnt != dep) : ff;
    af = w ? (cnt < dep - m) : af;
    ef = w ? ef : (cnt != 0);
    ae = w ? ae : (cnt > n);
    chk("full", full_flag_n, ff);
    chk("almost full", almost_full_flag_n, af);
    chk("almost empty", almost_empty_flag_n, ae);
    chk("empty", empty_flag_n, ef);
    chk("data out", data_out, dout);
  endtask : op
  task automatic frst(input logic s);
    @(posedge pclk);
    fifo_reset_n <= 1'b0;
    write_enable_second_or_load <= s;
    repeat (3) @(posedge pclk);
    fifo_reset_n <= 1'b1;
    q.delete();
    {ff, af, ef, ae, dout} = {4'b1100, 9'h000};
  endtask : frst
  initial begin
    {presetn, fifo_reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
    // strap low, second read enable starts low
    {write_enable_primary_n, write_enable_second_or_load, output_enable_n} = 3'b100;
    {read_enable_primary_n, read_enable_second_n, data_in} = '0;
    wr_go = 1'b1;
    rd_go = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    wr_go <= 1'b0;
    rd_go <= 1'b0;
    @(posedge pclk);
    #1;
    chk("reset flags", {full_flag_n, almost_full_flag_n, almost_empty_flag_n, empty_flag_n},
      4'hc);
    chk("reset data", {data_out_oe_n, data_out}, 10'h000);
    $display("test reset done");
    for (int i = 0; i < 14; i++) begin
      if (i == 8) fifo_reset_n <= 1'b1;
      apb(rows[i].a, rows[i].w, rows[i].d);
      chk("apb data", rd, rows[i].e);
      chk("apb error", er, rows[i].r);
    end
    $display("test registers done");
    {ff, af, ef, ae, dout} = {4'b1100, 9'h000};
    dep = 256;
    n = 3;
    m = 5;
    for (int i = 0; i < 257; i++) op(1'b1, 4'b0100, (i == 256) ? 9'h1aa : i[8:0]);
    for (int i = 0; i < 259; i++) op(1'b0, (i == 100) ? 4'b0101 : 4'b0100, 9'h000);
    op(1'b1, 4'b0000, 9'h0aa);
    op(1'b1, 4'b1100, 9'h0bb);
    op(1'b1, 4'b0100, 9'h055);
    $display("test fill and drain done");
    frst(1'b1);
    // defaults rule in second enable mode
    n = 7;
    m = 7;
    apb(DCFSF_REG_EMPTY_OFF, 1'b1, 32'h3);
    apb(DCFSF_REG_STATUS, 1'b0, 32'h0);
    chk("status mode", rd, 32'h13);
    output_enable_n <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("oe off", data_out_oe_n, 1'b1);
    output_enable_n <= 1'b0;
    for (int i = 0; i < 251; i++) begin
      op(i != 7 && i != 9, (i == 7 || i == 9) ? 4'b0101 : 4'b0100, i[8:0]);
    end
    $display("test default offsets done");
    results();
  end
endmodule : dual_clock_fifo_status_flags_tb_top
bind dcfsf_fifo dcfsf_monitor u_mon (.pclk, .presetn, .fifo_reset_n, .psel, .penable, .pready,
  .write_clock, .read_clock, .read_enable_primary_n, .read_enable_second_n, .data_out,
  .full_flag_n, .almost_full_flag_n, .almost_empty_flag_n, .empty_flag_n);
